// ---- rtl/crf_core.sv ----
/*
  Banked core register file with flag register, stack pointer select,
  interrupt acceptance and an Avalon-MM slave for software access.
  Assumes the execution unit drives synchronous one-cycle requests and
  the bus master holds its request until waitrequest is seen low.
*/
// How it works
// - two banks of eight, one visible
// - bank flag zero/one picks bank zero/one
// - data regs 16 bit, first two byte-split
// - pairs zero+two, one+three form 32 bits
// - address regs 24 bit, general use
// - static and frame base 24 bit
// - program counter 24 bit, next instruction
// - vector table base 24 bit
// - two stack pointers, select flag picks
// - hardware ack or low swi clears select
// - enable flag gates maskable interrupts
// - any interrupt ack clears enable flag
// - three-bit priority level field
// - accept only above current priority level
// - carry updated on each alu flag update
// - zero flag follows zero result
// - sign flag follows negative result
// - overflow flag follows overflow
// - flag register 16 bit, gathers state
`timescale 1ns/100ps
`include "crf_regs.svh"

module crf_core
  import crf_pkg::*;
#(
  parameter int BUS_AW = 8
)(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // read ports
  input wire crf_reg_t i_rda_sel,
  input wire crf_acc_t i_rda_kind,
  input wire crf_reg_t i_rdb_sel,
  input wire crf_acc_t i_rdb_kind,
  output logic [31:0] o_rda_data,
  output logic [31:0] o_rdb_data,
  // write port
  input wire logic i_wr_en,
  input wire crf_reg_t i_wr_sel,
  input wire crf_acc_t i_wr_kind,
  input wire logic [31:0] i_wr_data,
  // program counter
  input wire logic i_pc_load,
  input wire logic [23:0] i_pc_value,
  input wire logic i_pc_adv,
  input wire logic [3:0] i_pc_len,
  // arithmetic flag update
  input wire logic i_alu_upd,
  input wire crf_size_t i_alu_size,
  input wire logic [31:0] i_alu_result,
  input wire logic i_alu_carry,
  input wire logic i_alu_ovf,
  // interrupts
  input wire logic i_irq_req,
  input wire logic i_irq_nmi,
  input wire logic [2:0] i_irq_level,
  input wire logic i_hw_ack,
  input wire logic i_sw_int,
  input wire logic [5:0] i_sw_num,
  output logic o_irq_accept,
  // state views
  output logic [15:0] o_flags,
  output logic [23:0] o_pc,
  output logic [23:0] o_vector_table_base,
  output logic [23:0] o_sp,
  // avalon-mm slave
  input wire logic [BUS_AW-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);

  // --------------------------------------------------------------------
  // parameter check
  // --------------------------------------------------------------------
  if (BUS_AW < 7)
  begin : g_bad_aw
    $error("crf_core: BUS_AW must be at least 7");
  end

  crf_state_t st;
  crf_state_t next_st;

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  // read one register of the visible bank
  function automatic logic [31:0] read_reg(input crf_state_t s,
                                           input crf_reg_t sel,
                                           input crf_acc_t k);
    logic bk;
    logic [1:0] ix;
    logic [31:0] v;
    bk = s.flags[`CRF_FLG_B];
    ix = sel[1:0];
    v = 32'h00000000;
    unique case (sel)
      CRF_R0, CRF_R1, CRF_R2, CRF_R3:
      begin
        v = {16'h0000, s.data[bk][ix]};
        if (!sel[1] && k == CRF_ACC_LO8)
          v = {24'h000000, s.data[bk][ix][7:0]};
        else if (!sel[1] && k == CRF_ACC_HI8)
          v = {24'h000000, s.data[bk][ix][15:8]};
        else if (!sel[1] && k == CRF_ACC_L32)
          v = {s.data[bk][{1'b1, ix[0]}], s.data[bk][ix]};
      end
      CRF_A0, CRF_A1, CRF_SB, CRF_FB:
        v = {8'h00, s.addr[bk][ix]};
      CRF_PC: v = {8'h00, s.pc};
      CRF_VECTOR_TABLE_BASE: v = {8'h00, s.vector_table_base};
      CRF_SP: v = {8'h00, s.sp_view};
      CRF_USP: v = {8'h00, s.user_stack_pointer};
      CRF_ISP: v = {8'h00, s.interrupt_stack_pointer};
      CRF_FLG: v = {16'h0000, s.flags};
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction

  // byte-lane merge of a bus write
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction

  // zero and sign of a sized result
  function automatic logic [1:0] zero_sign(input logic [31:0] r,
                                           input crf_size_t sz);
    logic [1:0] zs;
    unique case (sz)
      CRF_SZ8: zs = {r[7:0] == 8'h00, r[7]};
      CRF_SZ16: zs = {r[15:0] == 16'h0000, r[15]};
      CRF_SZ24: zs = {r[23:0] == 24'h000000, r[23]};
      CRF_SZ32: zs = {r == 32'h00000000, r[31]};
    endcase
    return zs;
  endfunction

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  logic [7:0] bus_ofs;
  logic [BUS_AW+7:0] addr_ext;
  logic [31:0] bus_old;
  logic [31:0] bus_new;
  logic cur_bank;
  logic [1:0] wix;
  logic [1:0] alu_zs;

  always_comb
  begin
    next_st = st;
    addr_ext = {8'h00, i_avs_address};
    bus_ofs = {addr_ext[7:2], 2'b00};
    bus_old = 32'h00000000;
    bus_new = 32'h00000000;
    cur_bank = st.flags[`CRF_FLG_B];
    wix = i_wr_sel[1:0];
    alu_zs = zero_sign(i_alu_result, i_alu_size);

    // registered read ports, old state seen
    next_st.rda = read_reg(st, i_rda_sel, i_rda_kind);
    next_st.rdb = read_reg(st, i_rdb_sel, i_rdb_kind);

    // bus: answer one cycle after the request, write at the ack edge
    unique case (st.bus)
      CRF_BUS_IDLE:
      begin
        if (i_avs_read || i_avs_write)
        begin
          next_st.bus = CRF_BUS_ACK;
          next_st.waitreq = 1'b0;
          next_st.rdata = 32'h00000000;
          if (i_avs_read)
          begin
            if (bus_ofs < `CRF_OFS_PC)
              next_st.rdata = bus_ofs[4]
                ? {8'h00, st.addr[bus_ofs[5]][bus_ofs[3:2]]}
                : {16'h0000, st.data[bus_ofs[5]][bus_ofs[3:2]]};
            else if (bus_ofs == `CRF_OFS_PC)
              next_st.rdata = {8'h00, st.pc};
            else if (bus_ofs == `CRF_OFS_VECTOR_TABLE_BASE)
              next_st.rdata = {8'h00, st.vector_table_base};
            else if (bus_ofs == `CRF_OFS_USP)
              next_st.rdata = {8'h00, st.user_stack_pointer};
            else if (bus_ofs == `CRF_OFS_ISP)
              next_st.rdata = {8'h00, st.interrupt_stack_pointer};
            else if (bus_ofs == `CRF_OFS_FLG)
              next_st.rdata = {16'h0000, st.flags};
            else if (bus_ofs == `CRF_OFS_STAT)
              next_st.rdata = {29'h0, st.accept,
                               st.flags[`CRF_FLG_U],
                               st.flags[`CRF_FLG_B]};
          end
        end
      end
      CRF_BUS_ACK:
      begin
        next_st.bus = CRF_BUS_IDLE;
        next_st.waitreq = 1'b1;
        if (i_avs_write)
        begin
          if (bus_ofs < `CRF_OFS_PC)
          begin
            bus_old = bus_ofs[4]
              ? {8'h00, st.addr[bus_ofs[5]][bus_ofs[3:2]]}
              : {16'h0000, st.data[bus_ofs[5]][bus_ofs[3:2]]};
            bus_new = merge(bus_old, i_avs_writedata, i_avs_byteenable);
            if (bus_ofs[4])
              next_st.addr[bus_ofs[5]][bus_ofs[3:2]] = bus_new[23:0];
            else
              next_st.data[bus_ofs[5]][bus_ofs[3:2]] = bus_new[15:0];
          end
          else if (bus_ofs == `CRF_OFS_PC)
          begin
            bus_new = merge({8'h00, st.pc}, i_avs_writedata,
                            i_avs_byteenable);
            next_st.pc = bus_new[23:0];
          end
          else if (bus_ofs == `CRF_OFS_VECTOR_TABLE_BASE)
          begin
            bus_new = merge({8'h00, st.vector_table_base}, i_avs_writedata,
                            i_avs_byteenable);
            next_st.vector_table_base = bus_new[23:0];
          end
          else if (bus_ofs == `CRF_OFS_USP)
          begin
            bus_new = merge({8'h00, st.user_stack_pointer}, i_avs_writedata,
                            i_avs_byteenable);
            next_st.user_stack_pointer = bus_new[23:0];
          end
          else if (bus_ofs == `CRF_OFS_ISP)
          begin
            bus_new = merge({8'h00, st.interrupt_stack_pointer}, i_avs_writedata,
                            i_avs_byteenable);
            next_st.interrupt_stack_pointer = bus_new[23:0];
          end
          else if (bus_ofs == `CRF_OFS_FLG)
          begin
            bus_new = merge({16'h0000, st.flags}, i_avs_writedata,
                            i_avs_byteenable);
            next_st.flags = bus_new[15:0] & `CRF_FLG_MASK;
          end
        end
      end
    endcase

    // execution write, visible bank only, wins over the bus
    if (i_wr_en)
    begin
      unique case (i_wr_sel)
        CRF_R0, CRF_R1, CRF_R2, CRF_R3:
        begin
          if (!i_wr_sel[1] && i_wr_kind == CRF_ACC_LO8)
            next_st.data[cur_bank][wix][7:0] = i_wr_data[7:0];
          else if (!i_wr_sel[1] && i_wr_kind == CRF_ACC_HI8)
            next_st.data[cur_bank][wix][15:8] = i_wr_data[7:0];
          else if (!i_wr_sel[1] && i_wr_kind == CRF_ACC_L32)
          begin
            next_st.data[cur_bank][wix] = i_wr_data[15:0];
            next_st.data[cur_bank][{1'b1, wix[0]}] = i_wr_data[31:16];
          end
          else
            next_st.data[cur_bank][wix] = i_wr_data[15:0];
        end
        CRF_A0, CRF_A1, CRF_SB, CRF_FB:
          next_st.addr[cur_bank][wix] = i_wr_data[23:0];
        CRF_PC: next_st.pc = i_wr_data[23:0];
        CRF_VECTOR_TABLE_BASE: next_st.vector_table_base = i_wr_data[23:0];
        CRF_SP:
        begin
          if (st.flags[`CRF_FLG_U])
            next_st.user_stack_pointer = i_wr_data[23:0];
          else
            next_st.interrupt_stack_pointer = i_wr_data[23:0];
        end
        CRF_USP: next_st.user_stack_pointer = i_wr_data[23:0];
        CRF_ISP: next_st.interrupt_stack_pointer = i_wr_data[23:0];
        CRF_FLG: next_st.flags = i_wr_data[15:0] & `CRF_FLG_MASK;
        default: next_st.flags = next_st.flags;
      endcase
    end

    // program counter: load wins over advance
    if (i_pc_load)
      next_st.pc = i_pc_value;
    else if (i_pc_adv)
      next_st.pc = st.pc + {20'h00000, i_pc_len};

    // arithmetic flags
    if (i_alu_upd)
    begin
      next_st.flags[`CRF_FLG_C] = i_alu_carry;
      next_st.flags[`CRF_FLG_Z] = alu_zs[1];
      next_st.flags[`CRF_FLG_S] = alu_zs[0];
      next_st.flags[`CRF_FLG_O] = i_alu_ovf;
    end

    // interrupt acceptance against enable flag and level
    next_st.accept = i_irq_req
      && (i_irq_nmi || st.flags[`CRF_FLG_I])
      && (i_irq_level >
          st.flags[`CRF_FLG_IPL_HI:`CRF_FLG_IPL_LO]);

    // acknowledge clears enable and, where due, stack select
    if (i_hw_ack || i_sw_int)
      next_st.flags[`CRF_FLG_I] = 1'b0;
    if (i_hw_ack || (i_sw_int && i_sw_num <= `CRF_SWI_U_MAX))
      next_st.flags[`CRF_FLG_U] = 1'b0;

    // stack view follows the next select flag
    next_st.sp_view = next_st.flags[`CRF_FLG_U] ? next_st.user_stack_pointer
                                                : next_st.interrupt_stack_pointer;
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st.data <= '0;
      st.addr <= '0;
      st.pc <= `CRF_RST_WORD24;
      st.vector_table_base <= `CRF_RST_WORD24;
      st.user_stack_pointer <= `CRF_RST_WORD24;
      st.interrupt_stack_pointer <= `CRF_RST_WORD24;
      st.sp_view <= `CRF_RST_WORD24;
      st.flags <= `CRF_RST_FLG;
      st.rda <= 32'h00000000;
      st.rdb <= 32'h00000000;
      st.accept <= 1'b0;
      st.bus <= CRF_BUS_IDLE;
      st.waitreq <= 1'b1;
      st.rdata <= 32'h00000000;
    end
    else
      st <= next_st;
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign o_rda_data = st.rda;
  assign o_rdb_data = st.rdb;
  assign o_irq_accept = st.accept;
  assign o_flags = st.flags;
  assign o_pc = st.pc;
  assign o_vector_table_base = st.vector_table_base;
  assign o_sp = st.sp_view;
  assign o_avs_readdata = st.rdata;
  assign o_avs_waitrequest = st.waitreq;

endmodule // crf_core

// ---- rtl/crf_regs.svh ----
/*
  Offsets, flag bit positions, reset values and fixed counts of the
  banked core register file. Assumes byte addressing on the register bus,
  one 32-bit word per register.
*/
`ifndef CRF_REGS_SVH
`define CRF_REGS_SVH

// ----------------------------------------------------------------------
// bus offsets (byte addresses)
// ----------------------------------------------------------------------
`define CRF_OFS_BANK0 8'h00
`define CRF_OFS_BANK1 8'h20
`define CRF_OFS_PC 8'h40
`define CRF_OFS_VECTOR_TABLE_BASE 8'h44
`define CRF_OFS_USP 8'h48
`define CRF_OFS_ISP 8'h4c
`define CRF_OFS_FLG 8'h50
`define CRF_OFS_STAT 8'h54

// ----------------------------------------------------------------------
// flag register fields
// ----------------------------------------------------------------------
`define CRF_FLG_C 0
`define CRF_FLG_D 1
`define CRF_FLG_Z 2
`define CRF_FLG_S 3
`define CRF_FLG_B 4
`define CRF_FLG_O 5
`define CRF_FLG_I 6
`define CRF_FLG_U 7
`define CRF_FLG_IPL_LO 12
`define CRF_FLG_IPL_HI 14
`define CRF_FLG_MASK 16'h70ff

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define CRF_RST_FLG 16'h0000
`define CRF_RST_WORD24 24'h000000
`define CRF_SWI_U_MAX 6'h1f

`endif

// ---- rtl/crf_pkg.sv ----
/*
  Types of the banked core register file: register selectors, access
  kinds, result sizes, bus states and the module state record.
  Assumes crf_regs.svh is not needed here.
*/
package crf_pkg;

  // register selector of the execution ports
  typedef enum logic [3:0] {
    CRF_R0 = 4'h0, CRF_R1 = 4'h1, CRF_R2 = 4'h2, CRF_R3 = 4'h3,
    CRF_A0 = 4'h4, CRF_A1 = 4'h5, CRF_SB = 4'h6, CRF_FB = 4'h7,
    CRF_PC = 4'h8, CRF_VECTOR_TABLE_BASE = 4'h9, CRF_SP = 4'ha, CRF_USP = 4'hb,
    CRF_ISP = 4'hc, CRF_FLG = 4'hd, CRF_NONE = 4'hf
  } crf_reg_t;

  // access kind
  typedef enum logic [1:0] {
    CRF_ACC_NAT = 2'h0, // native width of the register
    CRF_ACC_LO8 = 2'h1, // lower byte (data regs zero and one)
    CRF_ACC_HI8 = 2'h2, // upper byte (data regs zero and one)
    CRF_ACC_L32 = 2'h3  // paired long operand
  } crf_acc_t;

  // size of an arithmetic result
  typedef enum logic [1:0] {
    CRF_SZ8 = 2'h0, CRF_SZ16 = 2'h1, CRF_SZ24 = 2'h2, CRF_SZ32 = 2'h3
  } crf_size_t;

  // bus answer states, gray along the path
  typedef enum logic [0:0] {
    CRF_BUS_IDLE = 1'b0,
    CRF_BUS_ACK = 1'b1
  } crf_bus_t;

  typedef struct packed {
    logic [1:0][3:0][15:0] data;  // per bank: four data registers
    logic [1:0][3:0][23:0] addr;  // per bank: a0, a1, static, frame
    logic [23:0] pc;
    logic [23:0] vector_table_base;
    logic [23:0] user_stack_pointer;
    logic [23:0] interrupt_stack_pointer;
    logic [23:0] sp_view;
    logic [15:0] flags;
    logic [31:0] rda;
    logic [31:0] rdb;
    logic accept;
    crf_bus_t bus;
    logic waitreq;
    logic [31:0] rdata;
  } crf_state_t;

endpackage

// ---- sim/crf_core_sva.sv ----
/*
  Port assertions of the banked core register file.
  Assumes one clock, reset active high; bound onto crf_core.
*/
`timescale 1ns/100ps
`include "crf_regs.svh"
module crf_core_sva
  import crf_pkg::*;
#(
  parameter int BUS_AW = 8
)(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // execution side
  input wire logic i_pc_load,
  input wire logic [23:0] i_pc_value,
  input wire logic i_alu_upd,
  input wire crf_size_t i_alu_size,
  input wire logic [31:0] i_alu_result,
  input wire logic i_alu_carry,
  input wire logic i_alu_ovf,
  input wire logic i_irq_req,
  input wire logic i_irq_nmi,
  input wire logic [2:0] i_irq_level,
  input wire logic i_hw_ack,
  input wire logic i_sw_int,
  input wire logic [5:0] i_sw_num,
  input wire logic o_irq_accept,
  input wire logic [15:0] o_flags,
  input wire logic [23:0] o_pc,
  // register bus
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);
  wire logic acc_ok = i_irq_req && (i_irq_nmi || o_flags[`CRF_FLG_I])
    && (i_irq_level > o_flags[`CRF_FLG_IPL_HI:`CRF_FLG_IPL_LO]);
  wire logic z16 = i_alu_result[15:0] == 16'h0000;
  wire logic s16 = i_alu_result[15];
  sequence s_taken;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_answer;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  a_bus_answer: assert property (s_taken |=> s_answer)
    else $error("bus answer not one cycle after request");
  a_bus_quiet: assert property (!(i_avs_read || i_avs_write)
    && o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest dropped without request");
  a_irq_accept: assert property (acc_ok |=> o_irq_accept)
    else $error("eligible interrupt not accepted");
  a_irq_refuse: assert property (!acc_ok |=> !o_irq_accept)
    else $error("ineligible interrupt accepted");
  a_hw_clear: assert property (i_hw_ack |=> o_flags[7:6] == 2'b00)
    else $error("hardware ack left enable or select set");
  a_swi_clear: assert property (i_sw_int |=> !o_flags[6] &&
    ($past(i_sw_num) > `CRF_SWI_U_MAX || !o_flags[7]))
    else $error("software interrupt flags wrong");
  a_alu_cv: assert property (i_alu_upd |=> o_flags[0] == $past(i_alu_carry)
    && o_flags[5] == $past(i_alu_ovf))
    else $error("carry or overflow flag wrong");
  a_alu_zs: assert property (i_alu_upd && i_alu_size == CRF_SZ16
    |=> o_flags[2] == $past(z16) && o_flags[3] == $past(s16))
    else $error("zero or sign flag wrong");
  a_pc_load: assert property (i_pc_load |=> o_pc == $past(i_pc_value))
    else $error("program counter load lost");
  a_flag_rsvd: assert property ((o_flags & ~`CRF_FLG_MASK) == 16'h0000)
    else $error("reserved flag bits set");
endmodule // crf_core_sva

bind crf_core crf_core_sva #(.BUS_AW(BUS_AW)) u_sva (.*);

// ---- sim/crf_exec_model.sv ----
/*
  Execution-side partner: drives the execution ports by tasks.
  Assumes the bench calls one task at a time and reads the answers.
*/
`timescale 1ns/100ps
module crf_exec_model
  import crf_pkg::*;
(
  // clock
  input wire logic i_ref_clk
);
  crf_reg_t sel = CRF_NONE;
  crf_acc_t kind = CRF_ACC_NAT;
  crf_reg_t wsel = CRF_NONE;
  crf_acc_t wkind = CRF_ACC_NAT;
  crf_size_t sz = CRF_SZ16;
  logic [31:0] wdata = 32'h0, res = 32'h0;
  logic [23:0] pcv = 24'h0;
  logic [5:0] num = 6'h0;
  logic [3:0] len = 4'h0;
  logic [2:0] lvl = 3'h0;
  logic wr = 0, ld = 0, adv = 0, upd = 0, cy = 0, ov = 0;
  logic req = 0, nmi = 0, hw = 0, swi = 0;
  // strobes last one cycle, cleared at the taking edge
  task automatic fire;
    @(posedge i_ref_clk);
    {wr, ld, adv, upd, req, hw, swi} <= 7'h00;
    #1;
  endtask
  task automatic rd(input crf_reg_t s, input crf_acc_t k);
    @(posedge i_ref_clk);
    sel <= s;
    kind <= k;
    @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wrt(input crf_reg_t s, input crf_acc_t k,
                     input logic [31:0] d);
    @(posedge i_ref_clk);
    {wr, wsel, wkind, wdata} <= {1'b1, s, k, d};
    fire();
  endtask
  task automatic pc(input logic l, input logic [23:0] v,
                    input logic a, input logic [3:0] n);
    @(posedge i_ref_clk);
    {ld, pcv, adv, len} <= {l, v, a, n};
    fire();
  endtask
  task automatic alu(input crf_size_t z, input logic [31:0] r,
                     input logic c, o);
    @(posedge i_ref_clk);
    {upd, sz, res, cy, ov} <= {1'b1, z, r, c, o};
    fire();
  endtask
  task automatic irq(input logic n, input logic [2:0] l);
    @(posedge i_ref_clk);
    {req, nmi, lvl} <= {1'b1, n, l};
    fire();
  endtask
  task automatic ack(input logic h, s, input logic [5:0] n);
    @(posedge i_ref_clk);
    {hw, swi, num} <= {h, s, n};
    fire();
  endtask
endmodule // crf_exec_model

// ---- sim/crf_core_test.sv ----
/*
  Self-checking bench of the core register file: bus tasks, the
  execution partner and directed tests. Assumes a 200 MHz clock.
*/
`timescale 1ns/100ps
`include "crf_regs.svh"
module crf_core_test;
  import crf_pkg::*;
  logic i_ref_clk = 0;
  logic i_sys_rst = 1;
  logic [7:0] avs_addr = 8'h00;
  logic avs_rd = 0, avs_wr = 0;
  logic [3:0] avs_be = 4'hf;
  logic [31:0] avs_wdata = 32'h0, q;
  wire logic [31:0] rda_data, rdb_data, avs_rdata;
  wire logic [15:0] flags;
  wire logic [23:0] pc, sp, vector_table_base;
  wire logic accept, waitreq;
  int n_fail = 0;
  int comparisons = 0;
  logic [7:0] ofs [9] = '{8'h00, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
                          8'h2c, 8'h40, 8'h44};
  crf_exec_model ex (.i_ref_clk(i_ref_clk));
  crf_core dut (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_rda_sel(ex.sel), .i_rda_kind(ex.kind),
    .i_rdb_sel(ex.sel), .i_rdb_kind(ex.kind),
    .o_rda_data(rda_data), .o_rdb_data(rdb_data),
    .i_wr_en(ex.wr), .i_wr_sel(ex.wsel), .i_wr_kind(ex.wkind),
    .i_wr_data(ex.wdata), .i_pc_load(ex.ld), .i_pc_value(ex.pcv),
    .i_pc_adv(ex.adv), .i_pc_len(ex.len), .i_alu_upd(ex.upd),
    .i_alu_size(ex.sz), .i_alu_result(ex.res), .i_alu_carry(ex.cy),
    .i_alu_ovf(ex.ov), .i_irq_req(ex.req), .i_irq_nmi(ex.nmi),
    .i_irq_level(ex.lvl), .i_hw_ack(ex.hw), .i_sw_int(ex.swi),
    .i_sw_num(ex.num), .o_irq_accept(accept), .o_flags(flags),
    .o_pc(pc), .o_vector_table_base(vector_table_base), .o_sp(sp), .i_avs_address(avs_addr),
    .i_avs_read(avs_rd), .i_avs_write(avs_wr),
    .i_avs_writedata(avs_wdata), .i_avs_byteenable(avs_be),
    .o_avs_readdata(avs_rdata), .o_avs_waitrequest(waitreq)
  );
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_ref_clk);
    {avs_rd, avs_wr, avs_addr, avs_wdata} <= {!w, w, a, d};
    do
    begin
      @(posedge i_ref_clk);
    end while (waitreq !== 1'b0);
    q = avs_rdata;
    {avs_rd, avs_wr} <= 2'b00;
  endtask
  task automatic alu_chk(input crf_size_t z, input logic [31:0] r,
                         input logic c, o, input logic [15:0] e);
    ex.alu(z, r, c, o);
    chk("alu flags", {16'h0, e}, {16'h0, flags & 16'h002d});
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial
  begin
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  initial
  begin
    repeat (5000) @(posedge i_ref_clk);
    n_fail++;
    results();
  end
  initial
  begin
    repeat (12) @(posedge i_ref_clk);
    i_sys_rst <= 0;
    bus(0, `CRF_OFS_FLG, 0);
    chk("flags reset", 32'h0, q);
    bus(0, `CRF_OFS_PC, 0);
    chk("pc reset", 32'h0, q);
    foreach (ofs[i])
    begin
      bus(1, ofs[i], 32'hffffffff);
      bus(0, ofs[i], 0);
      chk("width", (ofs[i][4] || ofs[i] >= 8'h40) ? 32'hffffff : 32'hffff, q);
    end
    bus(1, 8'h58, 32'h1234);
    bus(0, 8'h58, 0);
    chk("unmapped", 32'h0, q);
    $display("test widths done");
    bus(1, `CRF_OFS_BANK0, 32'h1234);
    bus(1, `CRF_OFS_BANK0 + 8'h08, 32'h5678);
    bus(1, `CRF_OFS_BANK1, 32'habcd);
    ex.rd(CRF_R0, CRF_ACC_NAT);
    chk("bank0 data", 32'h1234, rda_data);
    chk("port b", 32'h1234, rdb_data);
    ex.rd(CRF_R0, CRF_ACC_HI8);
    chk("upper byte", 32'h12, rda_data);
    ex.rd(CRF_R0, CRF_ACC_LO8);
    chk("lower byte", 32'h34, rda_data);
    ex.rd(CRF_R0, CRF_ACC_L32);
    chk("long pair", 32'h56781234, rda_data);
    bus(1, `CRF_OFS_FLG, 32'h10);
    bus(0, `CRF_OFS_STAT, 0);
    chk("status", 32'h1, q);
    ex.rd(CRF_R0, CRF_ACC_NAT);
    chk("bank1 data", 32'habcd, rda_data);
    ex.wrt(CRF_A1, CRF_ACC_NAT, 32'h00abcdef);
    bus(0, `CRF_OFS_BANK1 + 8'h14, 0);
    chk("bank1 addr", 32'habcdef, q);
    bus(0, `CRF_OFS_BANK0 + 8'h14, 0);
    chk("bank0 addr", 32'hffffff, q);
    ex.wrt(CRF_R0, CRF_ACC_L32, 32'h11223344);
    bus(0, `CRF_OFS_BANK1 + 8'h08, 0);
    chk("long write", 32'h1122, q);
    ex.wrt(CRF_R0, CRF_ACC_HI8, 32'h55);
    ex.rd(CRF_R0, CRF_ACC_NAT);
    chk("upper write", 32'h5544, rda_data);
    avs_be <= 4'h2;
    bus(1, `CRF_OFS_BANK1, 32'h0000aa00);
    avs_be <= 4'hf;
    bus(0, `CRF_OFS_BANK1, 0);
    chk("byte lane", 32'haa44, q);
    ex.wrt(CRF_VECTOR_TABLE_BASE, CRF_ACC_NAT, 32'h00a5a5a4);
    chk("table base", 32'h00a5a5a4, {8'h0, vector_table_base});
    $display("test banks done");
    bus(1, `CRF_OFS_USP, 32'h100);
    bus(1, `CRF_OFS_ISP, 32'h200);
    bus(1, `CRF_OFS_FLG, 32'hc0);
    bus(0, `CRF_OFS_FLG, 0);
    chk("user sp", 32'h100, {8'h0, sp});
    ex.rd(CRF_SP, CRF_ACC_NAT);
    chk("sp read", 32'h100, rda_data);
    ex.ack(1, 0, 6'h00);
    chk("hw ack", 32'h0, {30'h0, flags[7:6]});
    bus(0, `CRF_OFS_FLG, 0);
    chk("intr sp", 32'h200, {8'h0, sp});
    bus(1, `CRF_OFS_FLG, 32'hc0);
    ex.ack(0, 1, 6'h20);
    chk("swi 32", 32'h2, {30'h0, flags[7:6]});
    ex.ack(0, 1, 6'h1f);
    chk("swi 31", 32'h0, {30'h0, flags[7:6]});
    $display("test stacks done");
    bus(1, `CRF_OFS_FLG, 32'h3040);
    bus(0, `CRF_OFS_FLG, 0);
    chk("level field", 32'h3040, q);
    for (int l = 0; l < 8; l++)
    begin
      ex.irq(0, 3'(l));
      chk("accept", {31'h0, l > 3}, {31'h0, accept});
    end
    bus(1, `CRF_OFS_FLG, 32'h3000);
    ex.irq(0, 3'h7);
    chk("masked", 32'h0, {31'h0, accept});
    ex.irq(1, 3'h7);
    chk("nmi", 32'h1, {31'h0, accept});
    ex.irq(1, 3'h3);
    chk("nmi level", 32'h0, {31'h0, accept});
    ex.irq(0, 3'h0);
    $display("test interrupts done");
    alu_chk(CRF_SZ16, 32'h0, 1, 0, 16'h05);
    alu_chk(CRF_SZ16, 32'h8000, 0, 1, 16'h28);
    alu_chk(CRF_SZ8, 32'h80, 1, 1, 16'h29);
    alu_chk(CRF_SZ8, 32'h100, 0, 0, 16'h04);
    alu_chk(CRF_SZ24, 32'h800000, 0, 0, 16'h08);
    alu_chk(CRF_SZ32, 32'h80000000, 0, 0, 16'h08);
    $display("test alu done");
    ex.pc(1, 24'h123456, 0, 4'h0);
    chk("pc load", 32'h123456, {8'h0, pc});
    ex.pc(0, 24'h0, 1, 4'hf);
    chk("pc step", 32'h123465, {8'h0, pc});
    ex.pc(1, 24'h10, 1, 4'h2);
    chk("pc both", 32'h10, {8'h0, pc});
    bus(1, `CRF_OFS_FLG, 32'h8f00);
    bus(0, `CRF_OFS_FLG, 0);
    chk("reserved", 32'h0, q);
    $display("test pc and reserved done");
    results();
  end
endmodule // crf_core_test
